// ---- pio_pkg.sv ----
// Shared constants and types for the strobed parallel port block.
// Assumes a single 50 MHz clock domain; nothing here holds state.
package pio_pkg;

  // Clock rate of the design, kept for reference by users of the block.
  localparam int CLK_PERIOD_NS = 20;

  // Data widths and the depth of the host command queue.
  localparam int DATA_W = 8;
  localparam int CMD_DEPTH = 8;

  // Host register selects.
  localparam logic [1:0] SEL_PA = 2'h0;
  localparam logic [1:0] SEL_PB = 2'h1;
  localparam logic [1:0] SEL_PC = 2'h2;
  localparam logic [1:0] SEL_CTRL = 2'h3;

  // Control word layout; the low seven bits map onto port_cfg_t.
  localparam logic [7:0] CTRL_RESET = 8'h9B;
  localparam int CW_MODE_SET = 7;
  localparam int BSR_SET = 0;
  localparam int BSR_IDX_LO = 1;
  localparam int BSR_IDX_HI = 3;

  // Port C line positions used by the handshakes.
  localparam int PC_SERVICE_REQUEST_B = 0;
  localparam int PC_FULL_B = 1;
  localparam int PC_HS_B = 2;
  localparam int PC_SERVICE_REQUEST_A = 3;
  localparam int PC_STB_A = 4;
  localparam int PC_IBF_A = 5;
  localparam int PC_ACK_A = 6;
  localparam int PC_OBF_A = 7;
  localparam int PC_UPPER_LO = 4;

  // Reset values of port samples; handshake inputs idle high.
  localparam logic [7:0] PC_IDLE = 8'hFF;
  localparam logic [7:0] BYTE_ZERO = 8'h00;
  localparam logic [7:0] BYTE_ONES = 8'hFF;
  localparam logic [1:0] A_MODE0 = 2'h0;
  localparam logic [1:0] A_MODE1 = 2'h1;

  // What a port C line does under the current configuration.
  typedef enum logic [3:0] {
    ROLE_IN = 4'b0000,
    ROLE_OUT = 4'b0001,
    ROLE_MASK_A1 = 4'b0010,
    ROLE_MASK_A2 = 4'b0011,
    ROLE_MASK_B = 4'b0100,
    ROLE_SERVICE_REQUEST_A = 4'b0101,
    ROLE_IBF_A = 4'b0110,
    ROLE_OBF_A = 4'b0111,
    ROLE_SERVICE_REQUEST_B = 4'b1000,
    ROLE_IBF_B = 4'b1001,
    ROLE_OBF_B = 4'b1010
  } pc_role_t;

  // Mode fields in control word bit order (bit 6 down to bit 0).
  typedef struct packed {
    logic [1:0] a_mode;
    logic a_in;
    logic cu_in;
    logic b_mode;
    logic b_in;
    logic cl_in;
  } port_cfg_t;

  // One queued host write.
  typedef struct packed {
    logic [1:0] sel;
    logic [7:0] data;
  } host_cmd_t;

endpackage

// ---- cmd_fifo.sv ----
// Queue of host writes in front of the port logic.
// Assumes one clock and a reset already synchronised by the parent.
`timescale 1ns/10ps
module cmd_fifo
  import pio_pkg::*;
#(
  parameter int WIDTH = 10,
  parameter int DEPTH = CMD_DEPTH
)
(
  input wire logic clk,
  input wire logic rst_n,
  input wire logic [WIDTH-1:0] in_data,
  input wire logic in_valid,
  output logic in_ready,
  output logic [WIDTH-1:0] out_data,
  output logic out_valid,
  input wire logic out_ready
);
  localparam int AW = (DEPTH > 1) ? $clog2(DEPTH) : 1;

  logic [WIDTH-1:0] mem [DEPTH];
  logic [AW-1:0] wr_ptr;
  logic [AW-1:0] rd_ptr;
  logic [AW:0] count;
  logic empty;
  wire push = in_valid & in_ready;
  wire pop = ~empty & out_ready;
  wire [AW:0] next_count = count + {{AW{1'b0}}, push} - {{AW{1'b0}}, pop};
  wire [AW-1:0] next_wr = (wr_ptr == AW'(DEPTH - 1)) ? '0 : wr_ptr + 1'b1;
  wire [AW-1:0] next_rd = (rd_ptr == AW'(DEPTH - 1)) ? '0 : rd_ptr + 1'b1;

  // Ready and empty are flops, so the host sees a glitch-free ready.
  assign out_valid = ~empty;
  assign out_data = mem[rd_ptr];

  // Storage carries no reset; only the pointers, count and flags need a defined start.
  always_ff @(posedge clk)
  begin
    if (push)
      mem[wr_ptr] <= in_data;
  end

  // Pointer and occupancy bookkeeping.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      wr_ptr <= '0;
      rd_ptr <= '0;
      count <= '0;
      in_ready <= 1'b1;
      empty <= 1'b1;
    end
    else
    begin
      if (push)
        wr_ptr <= next_wr;
      if (pop)
        rd_ptr <= next_rd;
      count <= next_count;
      in_ready <= (next_count != (AW+1)'(DEPTH));
      empty <= (next_count == '0);
    end
  end
endmodule

// ---- strobed_port_handshake.sv ----
// Strobed and bidirectional handshake logic of a three-port parallel I/O.
// Assumes host strobes are one-cycle pulses on clk and port pins are
// external tristate pads resolved outside from the out and oe signals.
`timescale 1ns/10ps
module strobed_port_handshake
  import pio_pkg::*;
(
  input wire logic clk,
  input wire logic rst_n,
  input wire host_cmd_t cmd_in,
  input wire logic cmd_valid,
  output logic cmd_ready,
  input wire logic host_rd,
  input wire logic [1:0] host_sel,
  output logic [7:0] host_rdata,
  output logic host_rvalid,
  input wire logic [7:0] pa_in,
  output logic [7:0] pa_out,
  output logic [7:0] pa_oe,
  input wire logic [7:0] pb_in,
  output logic [7:0] pb_out,
  output logic [7:0] pb_oe,
  input wire logic [7:0] pc_in,
  output logic [7:0] pc_out,
  output logic [7:0] pc_oe
);

  // Role of a port C line; used for drive, read-back and set/reset.
  function automatic pc_role_t role_of(input logic [2:0] idx,
                                       input port_cfg_t c);
    logic a_hs;
    logic a_ip;
    logic a_op;
    pc_role_t lo;
    pc_role_t hi;
    a_hs = (c.a_mode != A_MODE0);
    a_ip = c.a_mode[1] | (c.a_mode == A_MODE1 & c.a_in);
    a_op = c.a_mode[1] | (c.a_mode == A_MODE1 & ~c.a_in);
    lo = c.cl_in ? ROLE_IN : ROLE_OUT;
    hi = c.cu_in ? ROLE_IN : ROLE_OUT;
    case (idx)
      3'h0: role_of = c.b_mode ? ROLE_SERVICE_REQUEST_B : lo;
      3'h1: role_of = c.b_mode ? (c.b_in ? ROLE_IBF_B : ROLE_OBF_B) : lo;
      3'h2: role_of = c.b_mode ? ROLE_MASK_B : lo;
      3'h3: role_of = a_hs ? ROLE_SERVICE_REQUEST_A : lo;
      3'h4: role_of = a_ip ? ROLE_MASK_A2 : hi;
      3'h5: role_of = a_ip ? ROLE_IBF_A : hi;
      3'h6: role_of = a_op ? ROLE_MASK_A1 : hi;
      3'h7: role_of = a_op ? ROLE_OBF_A : hi;
      default: role_of = ROLE_IN;
    endcase
  endfunction

  logic rst_meta;
  logic rst_core_n;
  logic [7:0] pa_meta;
  logic [7:0] pa_s;
  logic [7:0] pb_meta;
  logic [7:0] pb_s;
  logic [7:0] pc_meta;
  logic [7:0] pc_s;
  port_cfg_t cfg;
  logic [7:0] pa_in_latch;
  logic [7:0] pa_out_latch;
  logic [7:0] pb_in_latch;
  logic [7:0] pb_out_latch;
  logic [7:0] pc_latch;
  logic ibf_a;
  logic obf_a_n;
  logic service_request_a_in;
  logic service_request_a_out;
  logic ibf_b;
  logic obf_b_n;
  logic service_request_b;
  logic mask_a1;
  logic mask_a2;
  logic mask_b;
  host_cmd_t q_cmd;
  logic q_valid;
  logic pop_ok;
  pc_role_t role [8];
  logic [7:0] pc_drive;
  logic [7:0] pc_pin;
  logic [7:0] pc_view;
  logic [7:0] bsr_hit;
  logic [7:0] next_pc_latch;

  // Release of reset through two flops; assertion is immediate.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      rst_meta <= 1'b0;
      rst_core_n <= 1'b0;
    end
    else
    begin
      rst_meta <= 1'b1;
      rst_core_n <= rst_meta;
    end
  end

  // Two-flop samplers on all port pins so one strobe is one event.
  always_ff @(posedge clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      pa_meta <= BYTE_ZERO;
      pa_s <= BYTE_ZERO;
      pb_meta <= BYTE_ZERO;
      pb_s <= BYTE_ZERO;
      pc_meta <= PC_IDLE;
      pc_s <= PC_IDLE;
    end
    else
    begin
      pa_meta <= pa_in;
      pa_s <= pa_meta;
      pb_meta <= pb_in;
      pb_s <= pb_meta;
      pc_meta <= pc_in;
      pc_s <= pc_meta;
    end
  end

  // Host writes queue here; port writes stall while the latch is unread.
  cmd_fifo #(
    .WIDTH($bits(host_cmd_t)),
    .DEPTH(CMD_DEPTH)
  ) u_cmd_fifo (
    .clk(clk),
    .rst_n(rst_core_n),
    .in_data(cmd_in),
    .in_valid(cmd_valid),
    .in_ready(cmd_ready),
    .out_data(q_cmd),
    .out_valid(q_valid),
    .out_ready(pop_ok)
  );

  // Mode decode; the two groups are configured independently.
  wire a_m1 = (cfg.a_mode == A_MODE1);
  wire a_m2 = cfg.a_mode[1];
  wire a_inp = a_m2 | (a_m1 & cfg.a_in);
  wire a_outp = a_m2 | (a_m1 & ~cfg.a_in);
  wire b_inp = cfg.b_mode & cfg.b_in;
  wire b_outp = cfg.b_mode & ~cfg.b_in;
  wire stb_a_n = pc_s[PC_STB_A];
  wire ack_a_n = pc_s[PC_ACK_A];
  wire hs_b_n = pc_s[PC_HS_B];

  // Host events; a pending port write waits for the peripheral to accept.
  wire stall = (q_cmd.sel == SEL_PA & a_outp & ~obf_a_n)
             | (q_cmd.sel == SEL_PB & b_outp & ~obf_b_n);
  assign pop_ok = ~stall;
  wire pop = q_valid & pop_ok;
  wire wr_pa = pop & (q_cmd.sel == SEL_PA);
  wire wr_pb = pop & (q_cmd.sel == SEL_PB);
  wire wr_pc = pop & (q_cmd.sel == SEL_PC);
  wire wr_ctl = pop & (q_cmd.sel == SEL_CTRL);
  wire wr_mode = wr_ctl & q_cmd.data[CW_MODE_SET];
  wire wr_bsr = wr_ctl & ~q_cmd.data[CW_MODE_SET];
  wire bsr_val = q_cmd.data[BSR_SET];
  wire [2:0] bsr_idx = q_cmd.data[BSR_IDX_HI:BSR_IDX_LO];
  wire rd_pa = host_rd & (host_sel == SEL_PA) & a_inp;
  wire rd_pb = host_rd & (host_sel == SEL_PB) & b_inp;

  // Per-line decode of port C: role, drive, pin value and read-back.
  genvar gi;
  generate
    for (gi = 0; gi < 8; gi++)
    begin : g_pc
      wire mode0_grp = (gi >= PC_UPPER_LO) ? (cfg.a_mode == A_MODE0)
                                           : ~cfg.b_mode;
      wire is_mask = (role[gi] == ROLE_MASK_A1)
                   | (role[gi] == ROLE_MASK_A2)
                   | (role[gi] == ROLE_MASK_B);
      assign role[gi] = role_of(3'(gi), cfg);
      assign bsr_hit[gi] = wr_bsr & (bsr_idx == 3'(gi));
      assign pc_drive[gi] = (role[gi] != ROLE_IN) & ~is_mask;
      // Plain port C writes reach mode 0 output lines only.
      assign next_pc_latch[gi] =
        wr_mode ? 1'b0 :
        (bsr_hit[gi] & role[gi] == ROLE_OUT) ? bsr_val :
        (wr_pc & mode0_grp & role[gi] == ROLE_OUT) ? q_cmd.data[gi] :
        pc_latch[gi];
      // Strobe and accept positions read back as their mask bits.
      assign pc_view[gi] =
        (role[gi] == ROLE_MASK_A1) ? mask_a1 :
        (role[gi] == ROLE_MASK_A2) ? mask_a2 :
        (role[gi] == ROLE_MASK_B) ? mask_b :
        pc_drive[gi] ? pc_out[gi] : pc_s[gi];
    end
  endgenerate

  // Set/reset of a handshake output line overrides that flag directly.
  wire bsr_ibf_a = bsr_hit[PC_IBF_A] & role[PC_IBF_A] == ROLE_IBF_A;
  wire bsr_obf_a = bsr_hit[PC_OBF_A] & role[PC_OBF_A] == ROLE_OBF_A;
  wire bsr_int_a = bsr_hit[PC_SERVICE_REQUEST_A] & role[PC_SERVICE_REQUEST_A] == ROLE_SERVICE_REQUEST_A;
  wire bsr_ibf_b = bsr_hit[PC_FULL_B] & role[PC_FULL_B] == ROLE_IBF_B;
  wire bsr_obf_b = bsr_hit[PC_FULL_B] & role[PC_FULL_B] == ROLE_OBF_B;
  wire bsr_int_b = bsr_hit[PC_SERVICE_REQUEST_B] & role[PC_SERVICE_REQUEST_B] == ROLE_SERVICE_REQUEST_B;
  // Set/reset at a strobe or accept input position steers a mask.
  wire bsr_m_a1 = bsr_hit[PC_ACK_A] & role[PC_ACK_A] == ROLE_MASK_A1;
  wire bsr_m_a2 = bsr_hit[PC_STB_A] & role[PC_STB_A] == ROLE_MASK_A2;
  wire bsr_m_b = bsr_hit[PC_HS_B] & role[PC_HS_B] == ROLE_MASK_B;

  // Full flags: a strobe arriving with a read keeps the flag set.
  wire next_ibf_a = wr_mode ? 1'b0 : bsr_ibf_a ? bsr_val :
                    (a_inp & ~stb_a_n) ? 1'b1 :
                    rd_pa ? 1'b0 : ibf_a;
  wire next_obf_a_n = wr_mode ? 1'b1 : bsr_obf_a ? bsr_val :
                      (wr_pa & a_outp) ? 1'b0 :
                      (a_outp & ~ack_a_n) ? 1'b1 : obf_a_n;
  wire next_ibf_b = wr_mode ? 1'b0 : bsr_ibf_b ? bsr_val :
                    (b_inp & ~hs_b_n) ? 1'b1 : rd_pb ? 1'b0 : ibf_b;
  wire next_obf_b_n = wr_mode ? 1'b1 : bsr_obf_b ? bsr_val :
                      (wr_pb & b_outp) ? 1'b0 :
                      (b_outp & ~hs_b_n) ? 1'b1 : obf_b_n;

  // Requests: the new flag values feed the set term, so a read or a
  // write that empties the condition also ends the request.
  wire set_a_in = a_inp & stb_a_n & next_ibf_a & mask_a2;
  wire set_a_out = a_outp & ack_a_n & next_obf_a_n & mask_a1;
  wire set_b = cfg.b_mode & hs_b_n & mask_b &
               (cfg.b_in ? next_ibf_b : next_obf_b_n);
  wire clr_b = cfg.b_in ? rd_pb : wr_pb;
  wire next_service_request_a_in = wr_mode ? 1'b0 : bsr_int_a ? bsr_val :
                        set_a_in | (service_request_a_in & ~rd_pa);
  wire next_service_request_a_out = wr_mode ? 1'b0 : bsr_int_a ? bsr_val :
                         set_a_out | (service_request_a_out & ~(wr_pa & a_outp));
  wire next_service_request_b = wr_mode ? 1'b0 : bsr_int_b ? bsr_val :
                     set_b | (service_request_b & ~clr_b);
  wire next_mask_a1 = wr_mode ? 1'b0 : bsr_m_a1 ? bsr_val : mask_a1;
  wire next_mask_a2 = wr_mode ? 1'b0 : bsr_m_a2 ? bsr_val : mask_a2;
  wire next_mask_b = wr_mode ? 1'b0 : bsr_m_b ? bsr_val : mask_b;

  // Value each port C line drives in the coming cycle.
  always_comb
  begin
    for (int i = 0; i < 8; i++)
    begin
      case (role[i])
        ROLE_OUT: pc_pin[i] = next_pc_latch[i];
        ROLE_SERVICE_REQUEST_A: pc_pin[i] = next_service_request_a_in | next_service_request_a_out;
        ROLE_IBF_A: pc_pin[i] = next_ibf_a;
        ROLE_OBF_A: pc_pin[i] = next_obf_a_n;
        ROLE_SERVICE_REQUEST_B: pc_pin[i] = next_service_request_b;
        ROLE_IBF_B: pc_pin[i] = next_ibf_b;
        ROLE_OBF_B: pc_pin[i] = next_obf_b_n;
        default: pc_pin[i] = 1'b0;
      endcase
    end
  end

  // Read data selection; the control word always reads with bit 7 set.
  wire [7:0] pa_view = a_inp ? pa_in_latch :
                       cfg.a_in ? pa_s : pa_out_latch;
  wire [7:0] pb_view = b_inp ? pb_in_latch :
                       cfg.b_in ? pb_s : pb_out_latch;
  wire [7:0] rd_view = (host_sel == SEL_PA) ? pa_view :
                       (host_sel == SEL_PB) ? pb_view :
                       (host_sel == SEL_PC) ? pc_view :
                       {1'b1, cfg};
  wire [7:0] next_pa_out = wr_mode ? BYTE_ZERO :
                           wr_pa ? q_cmd.data : pa_out_latch;
  wire [7:0] next_pb_out = wr_mode ? BYTE_ZERO :
                           wr_pb ? q_cmd.data : pb_out_latch;
  // Bidirectional drivers follow the accept line; else plain direction.
  wire pa_drive = a_m2 ? ~ack_a_n : ~cfg.a_in;
  wire pb_drive = ~cfg.b_in;

  // Configuration and data latches.
  always_ff @(posedge clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      cfg <= port_cfg_t'(CTRL_RESET[6:0]);
      pa_in_latch <= BYTE_ZERO;
      pb_in_latch <= BYTE_ZERO;
      pa_out_latch <= BYTE_ZERO;
      pb_out_latch <= BYTE_ZERO;
      pc_latch <= BYTE_ZERO;
    end
    else
    begin
      if (wr_mode)
        cfg <= port_cfg_t'(q_cmd.data[6:0]);
      if (a_inp & ~stb_a_n)
        pa_in_latch <= pa_s;
      if (b_inp & ~hs_b_n)
        pb_in_latch <= pb_s;
      pa_out_latch <= next_pa_out;
      pb_out_latch <= next_pb_out;
      pc_latch <= next_pc_latch;
    end
  end

  // Handshake flags and request masks; all cleared by reset.
  always_ff @(posedge clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      ibf_a <= 1'b0;
      obf_a_n <= 1'b1;
      service_request_a_in <= 1'b0;
      service_request_a_out <= 1'b0;
      ibf_b <= 1'b0;
      obf_b_n <= 1'b1;
      service_request_b <= 1'b0;
      mask_a1 <= 1'b0;
      mask_a2 <= 1'b0;
      mask_b <= 1'b0;
    end
    else
    begin
      ibf_a <= next_ibf_a;
      obf_a_n <= next_obf_a_n;
      service_request_a_in <= next_service_request_a_in;
      service_request_a_out <= next_service_request_a_out;
      ibf_b <= next_ibf_b;
      obf_b_n <= next_obf_b_n;
      service_request_b <= next_service_request_b;
      mask_a1 <= next_mask_a1;
      mask_a2 <= next_mask_a2;
      mask_b <= next_mask_b;
    end
  end

  // Pin and read-back registers; every output leaves from a flop.
  always_ff @(posedge clk or negedge rst_core_n)
  begin
    if (!rst_core_n)
    begin
      pa_out <= BYTE_ZERO;
      pa_oe <= BYTE_ZERO;
      pb_out <= BYTE_ZERO;
      pb_oe <= BYTE_ZERO;
      pc_out <= BYTE_ZERO;
      pc_oe <= BYTE_ZERO;
      host_rdata <= BYTE_ZERO;
      host_rvalid <= 1'b0;
    end
    else
    begin
      pa_out <= next_pa_out;
      pa_oe <= pa_drive ? BYTE_ONES : BYTE_ZERO;
      pb_out <= next_pb_out;
      pb_oe <= pb_drive ? BYTE_ONES : BYTE_ZERO;
      pc_out <= pc_pin;
      pc_oe <= pc_drive;
      host_rdata <= host_rd ? rd_view : host_rdata;
      host_rvalid <= host_rd;
    end
  end

  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_core_n);

  sequence s_load_low;
    a_inp && !stb_a_n && !wr_mode && !bsr_ibf_a;
  endsequence
  sequence s_full_seen;
    ##1 ibf_a && pa_in_latch == $past(pa_s);
  endsequence

  load_sets_full_a: assert property (s_load_low |-> s_full_seen)
    else $error("input full or latch missed a load pulse");
  read_clears_full_a: assert property (
    rd_pa && stb_a_n && !wr_mode && !bsr_ibf_a |=> !ibf_a)
    else $error("input full not cleared by read");
  input_request_a: assert property (
    a_inp && stb_a_n && ibf_a && mask_a2 && !rd_pa && !wr_mode
    && !bsr_int_a && !bsr_ibf_a |=> pc_out[PC_SERVICE_REQUEST_A])
    else $error("group A input request not raised");
  write_sets_out_a: assert property (
    wr_pa && a_outp |=> !obf_a_n ##1 !(wr_pa && a_outp))
    else $error("output full not driven low after write");
  write_clears_req_a: assert property (
    wr_pa && a_outp && !bsr_int_a |=> !service_request_a_out)
    else $error("output request not cleared by write");
  bidir_drive_a: assert property (
    a_m2 && !wr_mode |=> pa_oe == (!$past(ack_a_n) ? BYTE_ONES : BYTE_ZERO))
    else $error("bidirectional drivers not following accept");
  mode_clears_all_a: assert property (
    wr_mode |=> !mask_a1 && !mask_a2 && !mask_b && !ibf_a && obf_a_n
    && !service_request_a_in && !service_request_a_out && pa_out_latch == BYTE_ZERO)
    else $error("mode write left flags or masks set");
  reset_config_a: assert property (
    $rose(rst_core_n) |-> cfg == port_cfg_t'(CTRL_RESET[6:0]) && !pa_oe[0])
    else $error("reset configuration wrong");
  pc_read_masks_a: assert property (
    host_rd && host_sel == SEL_PC && a_m2 |=> host_rvalid
    && host_rdata[PC_STB_A] == $past(mask_a2)
    && host_rdata[PC_ACK_A] == $past(mask_a1))
    else $error("port C read lacks mask bits");
  bsr_mask_a2_a: assert property (
    bsr_m_a2 && !wr_mode |=> mask_a2 == $past(bsr_val) && !pc_oe[PC_STB_A])
    else $error("set/reset on strobe position misrouted");
endmodule

// ---- port_peer.sv ----
// Peripheral model that sits on the port pins of the strobed port block.
// Assumes the bench resolves each pin from both parties' drives.
`timescale 1ns/10ps
module port_peer
(
  input wire logic clk,
  input wire logic [7:0] pin_pa,
  input wire logic [7:0] pin_pc,
  output logic [7:0] drv_pa,
  output logic [7:0] drv_pc
);
  logic stb_n = 1'b1;
  logic ack_n = 1'b1;
  logic hs_b_n = 1'b1;
  logic [7:0] rx_byte = 8'h00;
  int ack_delay = 2;

  // Unused positions idle high, as if pulled up.
  assign drv_pc = {1'b1, ack_n, 1'b1, stb_n, 1'b1, hs_b_n, 2'h3};
  initial drv_pa = 8'h00;

  // Strobe one byte in; the data is inverted once its hold has run out.
  task strobe_in(input logic [7:0] d);
    drv_pa = d;
    stb_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 stb_n = 1'b1;
    repeat (2) @(posedge clk);
    #1 drv_pa = ~d;
  endtask

  // Accept a group B byte with a three-cycle low pulse on its line.
  task accept_b;
    hs_b_n = 1'b0;
    repeat (3) @(posedge clk);
    #1 hs_b_n = 1'b1;
  endtask

  // Answer a full output latch late on purpose, then take the byte when
  // the full flag rises; the bus is only trusted at that edge.
  always
  begin
    @(posedge clk);
    #1;
    if (pin_pc[7] === 1'b0)
    begin
      repeat (ack_delay) @(posedge clk);
      #1 ack_n = 1'b0;
      for (int i = 0; i < 40 && pin_pc[7] !== 1'b1; i++)
        @(posedge clk) #1;
      rx_byte = pin_pa;
      ack_n = 1'b1;
    end
  end
endmodule

// ---- tb_top.sv ----
// Self-checking bench for the strobed port handshake block.
// Assumes pio_pkg and the peripheral model in port_peer.sv.
`timescale 1ns/10ps
module tb_top;
  import pio_pkg::*;
  logic clk = 1'b0;
  logic rst_n = 1'b0;
  host_cmd_t cmd_in = '0;
  logic cmd_valid = 1'b0;
  logic cmd_ready;
  logic host_rd = 1'b0;
  logic [1:0] host_sel = 2'h0;
  logic host_rvalid;
  logic [7:0] host_rdata, pa_out, pa_oe, pb_out, pb_oe, pc_out, pc_oe;
  logic [7:0] drv_pa, drv_pc, pin_pa, pin_pb, pin_pc, rd_val;
  int num_errors = 0;
  int total_checks = 0;

  // A 50 MHz clock.
  always #10 clk = ~clk;

  // Each pin shows whichever party drives it; port B sees a fixed pattern.
  assign pin_pa = (pa_oe & pa_out) | (~pa_oe & drv_pa);
  assign pin_pb = (pb_oe & pb_out) | (~pb_oe & 8'h5A);
  assign pin_pc = (pc_oe & pc_out) | (~pc_oe & drv_pc);

  strobed_port_handshake dut_u (.clk(clk), .rst_n(rst_n),
    .cmd_in(cmd_in), .cmd_valid(cmd_valid), .cmd_ready(cmd_ready),
    .host_rd(host_rd), .host_sel(host_sel), .host_rdata(host_rdata),
    .host_rvalid(host_rvalid), .pa_in(pin_pa), .pa_out(pa_out),
    .pa_oe(pa_oe), .pb_in(pin_pb), .pb_out(pb_out), .pb_oe(pb_oe),
    .pc_in(pin_pc), .pc_out(pc_out), .pc_oe(pc_oe));
  port_peer peer_u (.clk(clk), .pin_pa(pin_pa), .pin_pc(pin_pc),
    .drv_pa(drv_pa), .drv_pc(drv_pc));

  task check(input string name, input logic [7:0] seen,
             input logic [7:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      num_errors++;
      $display("Error %s expected %h seen %h", name, exp, seen);
    end
  endtask

  task tick(input int n);
    repeat (n) @(posedge clk);
    #1;
  endtask

  task put(input logic [1:0] s, input logic [7:0] d);
    cmd_in = '{sel: s, data: d};
    cmd_valid = 1'b1;
    while (cmd_ready !== 1'b1)
      tick(1);
    tick(1);
    cmd_valid = 1'b0;
    tick(1);
  endtask

  task rd(input logic [1:0] s);
    host_sel = s;
    host_rd = 1'b1;
    tick(1);
    host_rd = 1'b0;
    check("rvalid", host_rvalid, 1'b1);
    rd_val = host_rdata;
    tick(1);
  endtask

  task wait_pc(input int idx, input logic val);
    int n;
    n = 0;
    while (pc_out[idx] !== val && n < 60)
    begin
      tick(1);
      n++;
    end
    check("pc_out bit", pc_out[idx], val);
  endtask

  task test_reset;
    rd(SEL_CTRL);
    check("ctrl", rd_val, CTRL_RESET);
    rd(SEL_PC);
    check("pc_read", rd_val, 8'hFF);
    check("pa_oe", pa_oe, 8'h00);
    check("pc_oe", pc_oe, 8'h00);
    $display("test_reset done");
  endtask

  task test_strobe_in;
    put(SEL_CTRL, 8'hB8);
    put(SEL_CTRL, 8'h09);
    tick(2);
    rd(SEL_PC);
    check("mask_in", rd_val[4], 1'b1);
    check("pc4_oe", pc_oe[4], 1'b0);
    peer_u.strobe_in(8'hA5);
    check("in_full", pc_out[5], 1'b1);
    wait_pc(3, 1'b1);
    rd(SEL_PA);
    check("pa_read", rd_val, 8'hA5);
    check("in_full", pc_out[5], 1'b0);
    check("req", pc_out[3], 1'b0);
    $display("test_strobe_in done");
  endtask

  task test_strobe_out;
    peer_u.ack_delay = 5;
    put(SEL_CTRL, 8'hA0);
    put(SEL_CTRL, 8'h0D);
    tick(2);
    rd(SEL_PC);
    check("mask_out", rd_val[6], 1'b1);
    put(SEL_PA, 8'h3C);
    wait_pc(7, 1'b0);
    check("pa_oe", pa_oe, 8'hFF);
    wait_pc(7, 1'b1);
    tick(2);
    check("rx", peer_u.rx_byte, 8'h3C);
    wait_pc(3, 1'b1);
    put(SEL_PA, 8'hC3);
    check("req", pc_out[3], 1'b0);
    tick(20);
    check("rx", peer_u.rx_byte, 8'hC3);
    put(SEL_CTRL, 8'hA0);
    tick(2);
    check("req", pc_out[3], 1'b0);
    rd(SEL_PC);
    check("mask_out", rd_val[6], 1'b0);
    $display("test_strobe_out done");
  endtask

  task test_bidir;
    put(SEL_CTRL, 8'hC0);
    put(SEL_CTRL, 8'h09);
    rd(SEL_PC);
    check("mask_in", rd_val[4], 1'b1);
    check("mask_out", rd_val[6], 1'b0);
    put(SEL_PA, 8'h77);
    wait_pc(7, 1'b0);
    check("pa_oe", pa_oe, 8'h00);
    wait_pc(7, 1'b1);
    tick(2);
    check("rx", peer_u.rx_byte, 8'h77);
    tick(4);
    check("pa_oe", pa_oe, 8'h00);
    peer_u.strobe_in(8'h9E);
    wait_pc(5, 1'b1);
    wait_pc(3, 1'b1);
    rd(SEL_PA);
    check("pa_read", rd_val, 8'h9E);
    $display("test_bidir done");
  endtask

  task test_mode0;
    put(SEL_CTRL, 8'h80);
    put(SEL_PC, 8'hC3);
    tick(3);
    check("pc_out", pc_out, 8'hC3);
    check("pc_oe", pc_oe, 8'hFF);
    rd(SEL_PC);
    check("pc_read", rd_val, 8'hC3);
    $display("test_mode0 done");
  endtask

  // Group A strobed input beside group B strobed output.
  task test_group_b;
    put(SEL_CTRL, 8'hBC);
    put(SEL_CTRL, 8'h05);
    put(SEL_PB, 8'h66);
    check("full_b", pc_out[1], 1'b0);
    check("req_b", pc_out[0], 1'b0);
    check("pb_pin", pin_pb, 8'h66);
    check("pa_oe", pa_oe, 8'h00);
    rd(SEL_PC);
    check("mask_b", rd_val[2], 1'b1);
    peer_u.accept_b;
    wait_pc(1, 1'b1);
    wait_pc(0, 1'b1);
    $display("test_group_b done");
  endtask

  task print_verdict;
    $display("Checks %0d mismatches %0d", total_checks, num_errors);
    if (num_errors == 0 && total_checks > 0)
      $display("Testbench passed");
    else
      $display("Testbench failed");
    $finish;
  endtask

  // Main sequence: reset for six cycles, then each scenario in turn.
  initial
  begin
    repeat (6) @(posedge clk);
    #1 rst_n = 1'b1;
    tick(3);
    test_reset;
    test_strobe_in;
    test_strobe_out;
    test_bidir;
    test_mode0;
    test_group_b;
    print_verdict;
  end

  // Watchdog well beyond the few hundred cycles the scenarios need.
  initial
  begin
    #(20 * 5000);
    num_errors++;
    print_verdict;
  end
endmodule
